// file: logic/incu_pkg.sv
package incu_pkg;

    // Instruction encodings
    localparam logic [7:0] OPC_INC_ACC      = 8'h04;
    localparam logic [7:0] OPC_INC_DIRECT   = 8'h05;
    localparam logic [6:0] OPC_INC_INDIRECT = 7'h03;
    localparam logic [4:0] OPC_INC_BANK     = 5'h01;
    localparam logic [7:0] OPC_INC_DATA_PTR  = 8'ha3;
    localparam logic [7:0] OPC_DEC_BRANCH_NZ = 8'hd5;

    // Clock phases inside one machine cycle of eight clocks
    localparam logic [2:0] PH_FETCH_OPC  = 3'h0;
    localparam logic [2:0] PH_FETCH_OPND = 3'h1;
    localparam logic [2:0] PH_OPC        = 3'h2;
    localparam logic [2:0] PH_OPND       = 3'h3;
    localparam logic [2:0] PH_READ       = 3'h4;
    localparam logic [2:0] PH_READ_VIS   = 3'h5;
    localparam logic [2:0] PH_WRITE      = 3'h6;
    localparam logic [2:0] PH_END        = 3'h7;
    localparam logic [4:0] CLK_PER_MC    = 5'h08;
    localparam logic [4:0] CLK_PER_2MC   = 5'h10;

    // Program counter advances
    localparam logic [15:0] LEN_ONE      = 16'h0001;
    localparam logic [15:0] LEN_TWO      = 16'h0002;

    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [7:0]  BYTE_MAX     = 8'hff;
    localparam logic [15:0] WORD_ONE     = 16'h0001;
    localparam logic [15:0] WORD_MAX     = 16'hffff;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;

    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} incu_st_e;

    typedef enum logic [2:0] {
        OP_NONE, OP_ACC, OP_BANK, OP_DIRECT, OP_INDIRECT, OP_DATA_PTR,
        OP_DEC_BRANCH
    } incu_op_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
    } incu_code_req_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
        logic       rmw;
        logic       indirect;
    } incu_mem_req_s;

    typedef struct packed {
        incu_st_e       st;
        incu_op_e       op;
        logic [2:0]     phase;
        logic           mc;
        logic [7:0]     opcode;
        logic [7:0]     opnd;
        logic [7:0]     result;
        logic [7:0]     acc;
        logic [15:0]    data_ptr;
        logic [15:0]    pc;
        logic [15:0]    start_pc;
        logic [4:0]     clk_cnt;
        incu_code_req_s code;
        incu_mem_req_s  mem;
        logic           done;
        logic           unsup;
    } incu_state_s;

    function automatic incu_op_e incu_decode(input logic [7:0] opc);
        incu_op_e op;
        op = OP_NONE;
        if (opc == OPC_INC_ACC) op = OP_ACC;
        else if (opc == OPC_INC_DIRECT) op = OP_DIRECT;
        else if (opc[7:1] == OPC_INC_INDIRECT) op = OP_INDIRECT;
        else if (opc[7:3] == OPC_INC_BANK) op = OP_BANK;
        else if (opc == OPC_INC_DATA_PTR) op = OP_DATA_PTR;
        else if (opc == OPC_DEC_BRANCH_NZ) op = OP_DEC_BRANCH;
        return op;
    endfunction : incu_decode

endpackage : incu_pkg

// file: logic/incu_unit.sv
// What this block does
// RL1: Decrement-branch: pc+2, decrement, branch if nonzero
// RL2: Byte increment wraps FFh to 00h silently
// RL3: Byte increments change no status flags
// RL4: Register, direct, indirect and accumulator forms
// RL5: Port operands read from output latch
// RL6: Accumulator increment: opcode 04h, 1 byte, 1 cycle
// RL7: Bank register increment: 00001rrr, 1 byte, 1 cycle
// RL8: Direct increment: opcode 05h, 2 bytes, 1 cycle
// RL9: Indirect increment: 0000011i, RAM byte, 1 cycle
// RL10: Data pointer increments modulo 2^16
// RL11: Low byte rollover carries into high byte
// RL12: Data pointer increment: A3h, 1 byte, 2 cycles
// RL13: Data pointer is the only 16-bit increment
// RL14: Opcode bit 0 picks pointer register 0 or 1
// RL15: Result written back to location it came from
`timescale 1ns/100ps
module incu_unit
    import incu_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    input  wire logic           run,
    input  wire logic [1:0]     bank_sel,
    input  wire logic [7:0]     code_data,
    input  wire logic [7:0]     mem_rdata,
    output incu_code_req_s      code_req,
    output incu_mem_req_s       mem_req,
    output logic [7:0]          acc,
    output logic [15:0]         data_pointer,
    output logic [15:0]         program_counter,
    output logic                instr_done,
    output logic                unsupported
);

    incu_state_s q;
    incu_state_s d;
    logic [7:0]  bank_addr;
    logic        mem_op;
    logic        two_mc;

    // Bank registers sit in the low 32 bytes, eight per bank
    assign bank_addr = {3'h0, bank_sel, q.opcode[2:0]};
    assign mem_op    = (q.op == OP_BANK) || (q.op == OP_DIRECT) ||
                       (q.op == OP_INDIRECT) || (q.op == OP_DEC_BRANCH);
    assign two_mc    = (q.op == OP_DATA_PTR) || (q.op == OP_DEC_BRANCH);

    always_comb begin
        d          = q;
        d.code.rd  = 1'b0;
        d.mem.rd   = 1'b0;
        d.mem.wr   = 1'b0;
        d.mem.rmw  = 1'b0;
        d.done     = 1'b0;
        d.unsup    = 1'b0;
        d.clk_cnt  = q.clk_cnt + 5'h01;
        case (q.st)
            ST_IDLE: begin
                d.phase = PH_FETCH_OPC;
                d.mc    = 1'b0;
                if (run) begin
                    d.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                d.phase = q.phase + 3'h1;
                case (q.phase)
                    PH_FETCH_OPC: begin
                        d.code.rd = 1'b1;
                        if (!q.mc) begin
                            d.code.addr = q.pc;
                            d.start_pc  = q.pc;
                            d.clk_cnt   = 5'h01;
                        end else begin
                            // Displacement byte follows the address byte
                            d.code.addr = q.pc + LEN_TWO;
                        end
                    end
                    PH_FETCH_OPND: begin
                        if (!q.mc) begin
                            d.code.rd   = 1'b1;
                            d.code.addr = q.pc + LEN_ONE;
                        end
                    end
                    PH_OPC: begin
                        if (!q.mc) begin
                            d.opcode = code_data;
                            d.op     = incu_decode(code_data); // see RL4
                            // Pointer register is fetched first
                            if (code_data[7:1] == OPC_INC_INDIRECT) begin
                                d.mem.rd       = 1'b1;
                                d.mem.indirect = 1'b0;
                                d.mem.addr     = {3'h0, bank_sel, 2'h0,
                                                  code_data[0]}; // see RL14
                            end
                        end else begin
                            d.opnd = code_data;
                        end
                    end
                    PH_OPND: begin
                        if (!q.mc) begin
                            d.opnd = code_data;
                        end
                    end
                    PH_READ: begin
                        if (!q.mc && mem_op) begin
                            d.mem.rd       = 1'b1;
                            // Latch, not pin, feeds read-modify-write
                            d.mem.rmw      = 1'b1; // see RL5
                            d.mem.indirect = (q.op == OP_INDIRECT);
                            case (q.op)
                                OP_BANK:     d.mem.addr = bank_addr; // see RL7
                                OP_INDIRECT: d.mem.addr = mem_rdata; // see RL9
                                default:     d.mem.addr = q.opnd; // see RL8
                            endcase
                        end
                    end
                    PH_WRITE: begin
                        if (!q.mc && mem_op) begin
                            // Same address as the read, two clocks later
                            d.mem.wr  = 1'b1; // see RL15
                            d.mem.rmw = 1'b1;
                            if (q.op == OP_DEC_BRANCH) begin
                                d.mem.wdata = mem_rdata - BYTE_ONE; // see RL1
                            end else begin
                                // 8-bit add drops the carry on purpose
                                d.mem.wdata = mem_rdata + BYTE_ONE; // see RL2
                            end
                            d.result = d.mem.wdata;
                        end else if (!q.mc && q.op == OP_ACC) begin
                            d.acc = q.acc + BYTE_ONE; // see RL6
                        end else if (q.mc && q.op == OP_DATA_PTR) begin
                            // Full 16-bit add: low rollover carries up
                            d.data_ptr = q.data_ptr + WORD_ONE;
                            // see RL10 RL11 RL13
                        end
                        // No flag outputs exist: increments touch none
                        // see RL3
                    end
                    PH_END: begin
                        if (!q.mc && two_mc) begin
                            d.mc = 1'b1;
                        end else begin
                            d.mc   = 1'b0;
                            d.done = 1'b1;
                            d.unsup = (q.op == OP_NONE);
                            case (q.op)
                                OP_DIRECT: d.pc = q.pc + LEN_TWO; // see RL8
                                OP_DEC_BRANCH: begin
                                    if (q.result != BYTE_ZERO) begin
                                        d.pc = q.pc + LEN_TWO +
                                               {{8{q.opnd[7]}}, q.opnd};
                                    end else begin
                                        d.pc = q.pc + LEN_TWO; // see RL1
                                    end
                                end
                                default: d.pc = q.pc + LEN_ONE; // see RL12
                            endcase
                            if (!run) begin
                                d.st = ST_IDLE;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign code_req        = q.code;
    assign mem_req         = q.mem;
    assign acc             = q.acc;
    assign data_pointer    = q.data_ptr;
    assign program_counter = q.pc;
    assign instr_done      = q.done;
    assign unsupported     = q.unsup;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_branch_taken_pc: assert property ( // see RL1
        q.done && q.op == OP_DEC_BRANCH && q.result != BYTE_ZERO |->
            q.pc == q.start_pc + LEN_TWO + {{8{q.opnd[7]}}, q.opnd})
        else $error("decrement-branch taken target wrong");

    a_branch_fall_pc: assert property ( // see RL1
        q.done && q.op == OP_DEC_BRANCH && q.result == BYTE_ZERO |->
            q.pc == q.start_pc + LEN_TWO)
        else $error("decrement-branch fall-through pc wrong");

    a_byte_inc_wrap: assert property ( // see RL2
        q.mem.wr && q.op != OP_DEC_BRANCH |->
            q.mem.wdata == $past(mem_rdata) + BYTE_ONE)
        else $error("byte increment result wrong");

    a_rmw_latch_read: assert property ( // see RL5
        q.mem.rd && q.phase == PH_READ_VIS |-> q.mem.rmw)
        else $error("operand read not marked as latch read");

    a_one_cycle_len: assert property ( // see RL6
        q.done && q.op == OP_ACC |->
            q.clk_cnt == CLK_PER_MC && q.pc == q.start_pc + LEN_ONE)
        else $error("accumulator increment length or timing wrong");

    a_bank_reg_addr: assert property ( // see RL7
        q.mem.rd && q.phase == PH_READ_VIS && q.op == OP_BANK |->
            q.mem.addr == bank_addr)
        else $error("bank register address wrong");

    a_direct_len: assert property ( // see RL8
        q.done && q.op == OP_DIRECT |->
            q.clk_cnt == CLK_PER_MC && q.pc == q.start_pc + LEN_TWO)
        else $error("direct increment length or timing wrong");

    a_indirect_addr: assert property ( // see RL9
        q.mem.rd && q.phase == PH_READ_VIS && q.op == OP_INDIRECT |->
            q.mem.addr == $past(mem_rdata) && q.mem.indirect)
        else $error("indirect target address wrong");

    a_data_ptr_step: assert property ( // see RL10
        q.data_ptr != $past(q.data_ptr) |->
            q.data_ptr == $past(q.data_ptr) + WORD_ONE)
        else $error("data pointer step wrong");

    a_data_ptr_cycles: assert property ( // see RL12
        q.done && q.op == OP_DATA_PTR |-> q.clk_cnt == CLK_PER_2MC)
        else $error("data pointer increment not two cycles");

    a_write_same_addr: assert property ( // see RL15
        q.mem.wr |-> q.mem.addr == $past(q.mem.addr))
        else $error("write-back address differs from read");

    c_branch_taken: cover property (
        q.done && q.op == OP_DEC_BRANCH && q.result != BYTE_ZERO);
    c_data_ptr_wrap: cover property (
        $past(q.data_ptr) == WORD_MAX && q.data_ptr == WORD_ZERO);
    c_byte_wrap: cover property (
        q.mem.wr && q.mem.wdata == BYTE_ZERO && q.op != OP_DEC_BRANCH);
    c_indirect_done: cover property (q.done && q.op == OP_INDIRECT);

endmodule : incu_unit

// file: verification/increment_instruction_unit_bench.sv
`timescale 1ns/100ps
module increment_instruction_unit_bench
    import incu_pkg::*;
;
    localparam int LIMIT = 20000;
    logic           ref_clk = 1'b0;
    logic           resetn = 1'b0;
    logic           run = 1'b0;
    logic [1:0]     bank_sel = 2'h0;
    logic [7:0]     code_data;
    logic [7:0]     mem_rdata;
    incu_code_req_s code_req;
    incu_mem_req_s  mem_req;
    logic [7:0]     acc;
    logic [15:0]    data_pointer;
    logic [15:0]    program_counter;
    logic [15:0]    p;
    logic           instr_done;
    logic           unsupported;
    int             fails = 0;
    int             num_checks = 0;
    int             cycles = 0;

    always #4 ref_clk = ~ref_clk;

    incu_unit DUT (.ref_clk(ref_clk), .resetn(resetn), .run(run),
        .bank_sel(bank_sel), .code_data(code_data), .mem_rdata(mem_rdata),
        .code_req(code_req), .mem_req(mem_req), .acc(acc),
        .data_pointer(data_pointer), .program_counter(program_counter),
        .instr_done(instr_done), .unsupported(unsupported));

    incu_mem_model far_side (.ref_clk(ref_clk), .code_req(code_req),
        .mem_req(mem_req), .code_data(code_data), .mem_rdata(mem_rdata));

    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // One instruction; cycles counted from the first fetch pulse to done
    task automatic exec(input logic [7:0] b0, b1, b2, input int mc,
                        input logic unsup);
        int n;
        p = program_counter;
        far_side.prog[p] = b0;
        far_side.prog[p + 16'h0001] = b1;
        far_side.prog[p + 16'h0002] = b2;
        run = 1'b1;
        n = 0;
        while (code_req.rd !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        run = 1'b0;
        n = 0;
        while (instr_done !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check("cycles", 16'(n), 16'(8 * mc - 1));
        check("unsupported", {15'h0, unsupported}, {15'h0, unsup});
    endtask : exec

    task automatic s_acc();
        for (int i = 1; i <= 256; i++) begin
            exec(8'h04, 8'h00, 8'h00, 1, 1'b0);
            check("acc", {8'h00, acc}, {8'h00, 8'(i)});
            check("pc", program_counter, p + 16'h0001);
        end
    endtask : s_acc

    task automatic s_bank();
        logic [7:0] a;
        logic [7:0] v;
        for (int b = 0; b < 4; b++) begin
            for (int r = 0; r < 8; r++) begin
                bank_sel = 2'(b);
                a = {3'h0, 2'(b), 3'(r)};
                v = (r == 7) ? 8'hff : 8'(b * 8 + r);
                far_side.mem[a] = v;
                exec({5'h01, 3'(r)}, 8'h00, 8'h00, 1, 1'b0);
                check("bank reg", {8'h00, far_side.mem[a]},
                      {8'h00, v + 8'h01});
                check("pc", program_counter, p + 16'h0001);
                check("acc", {8'h00, acc}, 16'h0000);
            end
        end
    endtask : s_bank

    task automatic s_direct();
        far_side.mem[8'h30] = 8'hff;
        far_side.mem[256 + 16] = 8'h5a;
        exec(8'h05, 8'h30, 8'h00, 1, 1'b0);
        check("direct", {8'h00, far_side.mem[8'h30]}, 16'h0000);
        check("pc", program_counter, p + 16'h0002);
        exec(8'h05, 8'h90, 8'h00, 1, 1'b0);
        check("port", {8'h00, far_side.mem[256 + 16]}, 16'h005b);
    endtask : s_direct

    task automatic s_indirect();
        bank_sel = 2'h2;
        far_side.mem[8'h10] = 8'h7e;
        far_side.mem[8'h11] = 8'h90;
        far_side.mem[8'h7e] = 8'hff;
        far_side.mem[8'h90] = 8'h40;
        far_side.mem[256 + 16] = 8'h77;
        exec(8'h06, 8'h00, 8'h00, 1, 1'b0);
        check("at r0", {8'h00, far_side.mem[8'h7e]}, 16'h0000);
        check("pc", program_counter, p + 16'h0001);
        exec(8'h07, 8'h00, 8'h00, 1, 1'b0);
        check("at r1", {8'h00, far_side.mem[8'h90]}, 16'h0041);
        check("sfr", {8'h00, far_side.mem[256 + 16]}, 16'h0077);
    endtask : s_indirect

    task automatic s_data_ptr();
        for (int i = 1; i <= 257; i++) begin
            exec(8'ha3, 8'h00, 8'h00, 2, 1'b0);
            check("data ptr", data_pointer, 16'(i));
            check("pc", program_counter, p + 16'h0001);
        end
    endtask : s_data_ptr

    // Counts 2, 1, 0: branch, fall through, branch after wrap below zero
    task automatic s_dec_branch();
        logic [7:0] v;
        for (int k = 2; k >= 0; k--) begin
            v = 8'(k);
            far_side.mem[8'h40] = v;
            exec(8'hd5, 8'h40, 8'hfd, 2, 1'b0);
            check("count", {8'h00, far_side.mem[8'h40]},
                  {8'h00, v - 8'h01});
            check("pc", program_counter, p + 16'h0002
                  + ((v == 8'h01) ? 16'h0000 : 16'hfffd));
        end
    endtask : s_dec_branch

    task automatic s_unsup();
        exec(8'h00, 8'h00, 8'h00, 1, 1'b1);
        check("pc", program_counter, p + 16'h0001);
        check("acc", {8'h00, acc}, 16'h0000);
        // Only the data pointer steps as a word; 257 steps so far
        check("data ptr", data_pointer, 16'h0101);
    endtask : s_unsup

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        check("pc", program_counter, 16'h0000);
        check("data ptr", data_pointer, 16'h0000);
        s_acc();
        s_bank();
        s_direct();
        s_indirect();
        s_data_ptr();
        s_dec_branch();
        s_unsup();
        tally_and_finish();
    end
endmodule : increment_instruction_unit_bench

// file: verification/incu_mem_model.sv
`timescale 1ns/100ps
module incu_mem_model
    import incu_pkg::*;
(
    input  wire logic     ref_clk,
    input  incu_code_req_s code_req,
    input  incu_mem_req_s  mem_req,
    output logic [7:0]    code_data,
    output logic [7:0]    mem_rdata
);
    logic [7:0] prog [0:65535];
    // 0..255 internal RAM, 256..383 special-function latches
    logic [7:0] mem [0:383];

    function automatic int slot(input incu_mem_req_s r);
        return (!r.indirect && r.addr[7]) ? 256 + r.addr[6:0] : r.addr;
    endfunction : slot

    initial begin
        code_data = 8'h00;
        mem_rdata = 8'h00;
    end

    // Released lines show the inverse, so stale data never looks valid
    always @(posedge ref_clk) begin
        if (code_req.rd) begin
            code_data <= prog[code_req.addr];
        end else begin
            code_data <= ~code_data;
        end
        if (mem_req.rd && slot(mem_req) >= 256 && !mem_req.rmw) begin
            mem_rdata <= ~mem[slot(mem_req)];
        end else if (mem_req.rd) begin
            mem_rdata <= mem[slot(mem_req)];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_req.wr) begin
            mem[slot(mem_req)] <= mem_req.wdata;
        end
    end
endmodule : incu_mem_model
